// ===== src/oemc_ctrl.sv
// Output enable, margin and fault response control of the power stage
`timescale 1ns/1ps
`include "oemc_map.svh"

// Behaviour
// RQ1 - Warnings keep switching, alert, drop power-good
// RQ2 - Undervoltage and turn-on timeout obey configured response
// RQ3 - Always fixed-frequency continuous conduction
// RQ4 - Low-side on-time ramps over 128 periods
// RQ5 - Pin-only mode ignores command on bit
// RQ6 - Pin polarity selectable, factory pin-only high
// RQ7 - Command-only mode ignores enable pin
// RQ8 - Combined mode needs pin and command
// RQ9 - Mode holds until new write or pin
// RQ10 - Loop slave NACKs command access, flags alert
// RQ11 - On bit clear stops; set needs input, gating, no fault
// RQ12 - Soft bit chooses immediate or delayed ramp-down
// RQ13 - Read-only command bits discard written values
// RQ14 - On with soft bit is invalid data
// RQ15 - Margin 0001 nominal, faults responses suppressed
// RQ16 - Margin 0000, 0010, 0011 nominal, faults act
// RQ17 - Margin low/high codes with ignore or act
// RQ18 - Other margin codes rejected as invalid data
// RQ19 - Margin target from setpoint, trim, step, scale
// RQ20 - Ignored faults still set status and alert
// RQ21 - Host masks undervoltage alert before margining; the bench host margins with ALERT_MASK_I left at 00
// RQ22 - Rejected writes keep previous register and mode
module oemc_ctrl #(
  parameter int TURN_UP_RAMP_TIME_CYC = `OEMC_TURN_UP_RAMP_TIME_CYC,
  parameter int TURNOFF_WAIT_TIME_CYC = `OEMC_TURNOFF_WAIT_TIME_CYC,
  parameter int TURNOFF_RAMP_TIME_CYC = `OEMC_TURNOFF_RAMP_TIME_CYC,
  parameter int PWM_PERIOD = `OEMC_PWM_PERIOD,
  parameter int SS_PERIODS = `OEMC_SS_PERIODS
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // Command access port
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic [7:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_WDATA_I,
  output logic [7:0] CMD_RDATA_O,
  output logic CMD_ACK_O,
  output logic CMD_NACK_O,
  // Configuration levels
  input wire logic [4:0] ON_OFF_CFG_I,
  input wire logic LOOP_SLAVE_I,
  input wire logic [1:0] UV_RESP_I,
  input wire logic [1:0] OV_RESP_I,
  input wire logic [1:0] TON_RESP_I,
  input wire logic [7:0] ALERT_MASK_I,
  input wire logic CLEAR_FAULTS_I,
  // Enable control pin and supervisors
  input wire logic ENABLE_CONTROL_PIN_I,
  input wire logic VIN_OK_I,
  input wire logic OV_WARN_I,
  input wire logic UV_WARN_I,
  input wire logic OV_FAULT_I,
  input wire logic UV_FAULT_I,
  input wire logic TON_MAX_FAULT_I,
  // Setpoint arithmetic inputs
  input wire logic [15:0] NOMINAL_SETPOINT_I,
  input wire logic signed [15:0] REF_TRIM_I,
  input wire logic [15:0] MARGIN_LOW_STEP_I,
  input wire logic [15:0] MARGIN_HIGH_STEP_I,
  input wire logic [3:0] FEEDBACK_SCALE_SHIFT_I,
  input wire logic [15:0] DUTY_I,
  // Outputs
  output logic HS_GATE_O,
  output logic LS_GATE_O,
  output logic POWER_GOOD_OUTPUT_O,
  output logic ALERT_O,
  output logic [7:0] STATUS_O,
  output logic [15:0] TARGET_O,
  output logic RAMP_UP_O,
  output logic RAMP_DOWN_O
);

  localparam int RETRY_CYC = `OEMC_RETRY_RAMPS * TURN_UP_RAMP_TIME_CYC;

  oemc_pkg::oemc_ctrl_t s_q; // Registered state
  oemc_pkg::oemc_ctrl_t s_d; // Next state
  logic [3:0] mrg; // Stored margin field
  logic [3:0] wmrg; // Margin field being written
  logic pin_act; // Enable pin after polarity
  logic req_on; // Conversion requested
  logic cmd_hit; // Access addresses the command register
  logic wr_bad; // Written value is invalid data
  logic flt_ign; // Margin mode ignores output faults
  logic run; // Power stage is switching
  logic [7:0] ev; // Events raised this cycle
  logic signed [16:0] step; // Trim combined with margin step
  logic signed [16:0] shifted; // Step divided by loop scale
  logic [31:0] lim; // Count limit for the present state

  // Power stage switching, gated by the sequencer
  oemc_pwm #(
    .PERIOD(PWM_PERIOD),
    .SS_PERIODS(SS_PERIODS)
  ) u_pwm (
    .clk_i(REF_CLK_I),
    .reset_n_i(RESET_N_I),
    .ce_i(CE_I),
    .run_i(run),
    .duty_i(DUTY_I),
    .hs_o(HS_GATE_O),
    .ls_o(LS_GATE_O)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    ev = 8'h00;
    mrg = s_q.cmd[`OEMC_MRG_HI:`OEMC_MRG_LO];
    wmrg = CMD_WDATA_I[`OEMC_MRG_HI:`OEMC_MRG_LO];
    lim = 32'h0000_0000;
    s_d.ack = 1'b0;
    s_d.nack = 1'b0;

    // RQ6 polarity caught once after reset release
    if (!s_q.pol_ok) begin
      s_d.pol = ON_OFF_CFG_I[`OEMC_CFG_POL];
      s_d.pol_ok = 1'b1;
    end
    pin_act = s_q.pol ? ENABLE_CONTROL_PIN_I : ~ENABLE_CONTROL_PIN_I;

    // RQ5 RQ7 RQ8 gating by pin and/or command
    if (!ON_OFF_CFG_I[`OEMC_CFG_PU]) begin
      req_on = 1'b1;
    end else begin
      req_on = (ON_OFF_CFG_I[`OEMC_CFG_CPR] | ON_OFF_CFG_I[`OEMC_CFG_CMD])
        & (~ON_OFF_CFG_I[`OEMC_CFG_CPR] | pin_act)
        & (~ON_OFF_CFG_I[`OEMC_CFG_CMD] | s_q.cmd[`OEMC_ON_BIT]);
    end
    // All gating modes wait for the polarity capture
    req_on = req_on & s_q.pol_ok;

    // RQ15 RQ16 RQ17 ignore-fault margin codes
    flt_ign = (mrg == `OEMC_MRG_OFF_IGN) || (mrg == `OEMC_MRG_LOW_IGN)
      || (mrg == `OEMC_MRG_HIGH_IGN);

    // RQ18 valid codes are 00xx except none, 0101, 0110, 1001, 1010
    case (wmrg)
      4'h0, 4'h1, 4'h2, 4'h3, `OEMC_MRG_LOW_IGN, `OEMC_MRG_LOW_ACT,
      `OEMC_MRG_HIGH_IGN, `OEMC_MRG_HIGH_ACT: begin
        wr_bad = 1'b0;
      end
      default: begin
        wr_bad = 1'b1;
      end
    endcase
    // RQ14 on and soft bits together
    if (CMD_WDATA_I[`OEMC_ON_BIT] && CMD_WDATA_I[`OEMC_SOFT_BIT]) begin
      wr_bad = 1'b1;
    end

    // Command access decode
    cmd_hit = CMD_ADDR_I == `OEMC_CMD_ADDR;
    if (CMD_WR_I || CMD_RD_I) begin
      if (!cmd_hit) begin
        // Unsupported command: refused, communication flag
        s_d.nack = 1'b1;
        ev[`OEMC_ST_CML] = 1'b1;
      end else if (LOOP_SLAVE_I) begin
        // RQ10 loop slave refuses, data ignored
        s_d.nack = 1'b1;
        ev[`OEMC_ST_IVC] = 1'b1;
      end else if (CMD_WR_I) begin
        s_d.ack = 1'b1;
        if (wr_bad) begin
          // RQ22 register left untouched
          ev[`OEMC_ST_CML] = 1'b1;
          ev[`OEMC_ST_IVD] = 1'b1;
        end else begin
          // RQ13 read-only bits dropped
          s_d.cmd = CMD_WDATA_I & `OEMC_RO_MASK;
        end
      end else begin
        // Read returns stored command, low bits zero
        s_d.ack = 1'b1;
        s_d.rdata = s_q.cmd;
      end
    end

    // RQ1 overvoltage warning during ramp and on
    if (OV_WARN_I && (s_q.state == oemc_pkg::ST_RAMP
        || s_q.state == oemc_pkg::ST_ON)) begin
      ev[`OEMC_ST_OVW] = 1'b1;
    end
    // RQ1 undervoltage warning only once up
    if (UV_WARN_I && s_q.state == oemc_pkg::ST_ON) begin
      ev[`OEMC_ST_UVW] = 1'b1;
    end
    if (OV_FAULT_I && (s_q.state == oemc_pkg::ST_RAMP
        || s_q.state == oemc_pkg::ST_ON)) begin
      ev[`OEMC_ST_OVF] = 1'b1;
    end
    // RQ2 undervoltage and turn-on timeout faults not checked during the ramp
    if (s_q.state == oemc_pkg::ST_ON) begin
      ev[`OEMC_ST_UVF] = UV_FAULT_I;
      ev[`OEMC_ST_TON] = TON_MAX_FAULT_I;
    end

    // RQ20 status sticky, set wins over clear
    if (CLEAR_FAULTS_I) begin
      s_d.status = ev;
    end else begin
      s_d.status = s_q.status | ev;
    end
    s_d.alert = |(s_d.status & ~ALERT_MASK_I);

    // Sequencer
    s_d.cnt = s_q.cnt + 32'h0000_0001;
    case (s_q.state)
      oemc_pkg::ST_OFF: begin
        s_d.cnt = 32'h0000_0000;
        // RQ11 start needs input, gating, no fault
        if (req_on && VIN_OK_I && !OV_FAULT_I && !UV_FAULT_I) begin
          s_d.state = oemc_pkg::ST_RAMP;
        end
      end
      oemc_pkg::ST_RAMP, oemc_pkg::ST_ON: begin
        if (s_q.state == oemc_pkg::ST_RAMP
            && s_q.cnt >= 32'(TURN_UP_RAMP_TIME_CYC - 1)) begin
          s_d.state = oemc_pkg::ST_ON;
        end
        if (!req_on) begin
          s_d.cnt = 32'h0000_0000;
          // RQ12 soft bit picks stop style for command off
          if (ON_OFF_CFG_I[`OEMC_CFG_CMD]
              && !s_q.cmd[`OEMC_ON_BIT]) begin
            s_d.state = s_q.cmd[`OEMC_SOFT_BIT] ?
              oemc_pkg::ST_STOP_WAIT : oemc_pkg::ST_OFF;
          end else begin
            s_d.state = ON_OFF_CFG_I[`OEMC_CFG_CPA] ?
              oemc_pkg::ST_OFF : oemc_pkg::ST_STOP_WAIT;
          end
        end
        // RQ2 RQ15 output fault responses unless margin ignores
        if ((ev[`OEMC_ST_UVF] && !flt_ign
            && UV_RESP_I != `OEMC_RESP_IGNORE)
            || (ev[`OEMC_ST_OVF] && !flt_ign
            && OV_RESP_I != `OEMC_RESP_IGNORE)
            || (ev[`OEMC_ST_TON] && TON_RESP_I != `OEMC_RESP_IGNORE)) begin
          s_d.cnt = 32'h0000_0000;
          if ((ev[`OEMC_ST_UVF] && UV_RESP_I == `OEMC_RESP_LATCH)
              || (ev[`OEMC_ST_OVF] && OV_RESP_I == `OEMC_RESP_LATCH)
              || (ev[`OEMC_ST_TON] && TON_RESP_I == `OEMC_RESP_LATCH))
          begin
            s_d.state = oemc_pkg::ST_LATCHED;
          end else begin
            s_d.state = oemc_pkg::ST_RETRY;
          end
        end
      end
      oemc_pkg::ST_STOP_WAIT: begin
        lim = 32'(TURNOFF_WAIT_TIME_CYC - 1);
        if (s_q.cnt >= lim) begin
          s_d.cnt = 32'h0000_0000;
          s_d.state = oemc_pkg::ST_STOP_FALL;
        end
      end
      oemc_pkg::ST_STOP_FALL: begin
        lim = 32'(TURNOFF_RAMP_TIME_CYC - 1);
        if (s_q.cnt >= lim) begin
          s_d.state = oemc_pkg::ST_OFF;
        end
      end
      oemc_pkg::ST_RETRY: begin
        // RQ2 retry after seven ramp times
        lim = 32'(RETRY_CYC - 1);
        if (s_q.cnt >= lim) begin
          s_d.cnt = 32'h0000_0000;
          s_d.state = oemc_pkg::ST_OFF;
        end
      end
      oemc_pkg::ST_LATCHED: begin
        // Latched off until the request is withdrawn
        if (!req_on) begin
          s_d.state = oemc_pkg::ST_OFF;
        end
      end
      default: begin
        s_d.state = oemc_pkg::ST_OFF;
      end
    endcase
    // RQ11 input lockout shuts down at once
    if (!VIN_OK_I && s_q.state != oemc_pkg::ST_LATCHED) begin
      s_d.state = oemc_pkg::ST_OFF;
    end

    // RQ1 power-good drops on overvoltage and undervoltage warnings and faults
    s_d.power_good_output = (s_d.state == oemc_pkg::ST_ON) && !OV_WARN_I && !UV_WARN_I
      && !OV_FAULT_I && !UV_FAULT_I;

    // RQ19 margin target arithmetic
    case (mrg)
      `OEMC_MRG_LOW_IGN, `OEMC_MRG_LOW_ACT: begin
        step = 17'(REF_TRIM_I) - $signed({1'b0, MARGIN_LOW_STEP_I});
      end
      `OEMC_MRG_HIGH_IGN, `OEMC_MRG_HIGH_ACT: begin
        step = 17'(REF_TRIM_I) + $signed({1'b0, MARGIN_HIGH_STEP_I});
      end
      default: begin
        step = 17'sh00000;
      end
    endcase
    shifted = step >>> FEEDBACK_SCALE_SHIFT_I;
    s_d.target = 16'($signed({1'b0, NOMINAL_SETPOINT_I}) + shifted);
  end

  // RQ3 RQ11 gates run only in switching states
  assign run = (s_q.state == oemc_pkg::ST_RAMP)
    || (s_q.state == oemc_pkg::ST_ON)
    || (s_q.state == oemc_pkg::ST_STOP_WAIT)
    || (s_q.state == oemc_pkg::ST_STOP_FALL);

  // RQ9 state register holds mode between events
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_q <= '0;
      s_q.state <= oemc_pkg::ST_OFF;
      s_q.cmd <= `OEMC_CMD_RESET;
      s_q.pol <= 1'b1;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  // Output drive
  assign CMD_RDATA_O = s_q.rdata;
  assign CMD_ACK_O = s_q.ack;
  assign CMD_NACK_O = s_q.nack;
  assign POWER_GOOD_OUTPUT_O = s_q.power_good_output;
  assign ALERT_O = s_q.alert;
  assign STATUS_O = s_q.status;
  assign TARGET_O = s_q.target;
  assign RAMP_UP_O = s_q.state == oemc_pkg::ST_RAMP;
  assign RAMP_DOWN_O = s_q.state == oemc_pkg::ST_STOP_FALL;

endmodule : oemc_ctrl

// ===== src/oemc_map.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef OEMC_MAP_SVH
`define OEMC_MAP_SVH

// Command register address and reset value
`define OEMC_CMD_ADDR 8'h01
`define OEMC_CMD_RESET 8'h00
// Command register fields
`define OEMC_ON_BIT 7
`define OEMC_SOFT_BIT 6
`define OEMC_MRG_HI 5
`define OEMC_MRG_LO 2
`define OEMC_RO_MASK 8'hFC

// On/off configuration fields (power-up gate, cmd, pin, polarity, action)
`define OEMC_CFG_PU 4
`define OEMC_CFG_CMD 3
`define OEMC_CFG_CPR 2
`define OEMC_CFG_POL 1
`define OEMC_CFG_CPA 0
`define OEMC_CFG_FACTORY 5'h16

// Fault response codes
`define OEMC_RESP_IGNORE 2'h0
`define OEMC_RESP_LATCH 2'h1
`define OEMC_RESP_RESTART 2'h2

// Margin field codes
`define OEMC_MRG_OFF_IGN 4'h1
`define OEMC_MRG_LOW_IGN 4'h5
`define OEMC_MRG_LOW_ACT 4'h6
`define OEMC_MRG_HIGH_IGN 4'h9
`define OEMC_MRG_HIGH_ACT 4'hA

// Status flag positions (also alert mask positions)
`define OEMC_ST_OVW 0
`define OEMC_ST_UVW 1
`define OEMC_ST_OVF 2
`define OEMC_ST_UVF 3
`define OEMC_ST_TON 4
`define OEMC_ST_CML 5
`define OEMC_ST_IVD 6
`define OEMC_ST_IVC 7

// Timing: clock rate and ramp times in microseconds
`define OEMC_CLK_MHZ 100
`define OEMC_TURN_UP_RAMP_TIME_US 1000
`define OEMC_TURNOFF_WAIT_TIME_US 100
`define OEMC_TURNOFF_RAMP_TIME_US 1000
`define OEMC_TURN_UP_RAMP_TIME_CYC (`OEMC_TURN_UP_RAMP_TIME_US * `OEMC_CLK_MHZ)
`define OEMC_TURNOFF_WAIT_TIME_CYC (`OEMC_TURNOFF_WAIT_TIME_US * `OEMC_CLK_MHZ)
`define OEMC_TURNOFF_RAMP_TIME_CYC (`OEMC_TURNOFF_RAMP_TIME_US * `OEMC_CLK_MHZ)
`define OEMC_RETRY_RAMPS 7

// Switching: period in clock cycles and soft-start length in periods
`define OEMC_PWM_PERIOD 200
`define OEMC_SS_PERIODS 128

`endif

// ===== src/oemc_pkg.sv
// Types shared by the output enable and margin control block
package oemc_pkg;

  // Conversion sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_ON, ST_STOP_WAIT, ST_STOP_FALL, ST_RETRY, ST_LATCHED
  } oemc_state_t;

  // Complete state of the control module
  typedef struct packed {
    oemc_state_t state;
    logic [31:0] cnt;
    logic [7:0] cmd;
    logic pol;
    logic pol_ok;
    logic ack;
    logic nack;
    logic [7:0] rdata;
    logic [7:0] status;
    logic alert;
    logic power_good_output;
    logic [15:0] target;
  } oemc_ctrl_t;

  // Complete state of the switching module
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] ss;
    logic hs;
    logic ls;
  } oemc_pwm_t;

endpackage : oemc_pkg

// ===== src/oemc_pwm.sv
// Fixed-frequency gate timing with low-side soft-start
`timescale 1ns/1ps
`include "oemc_map.svh"

module oemc_pwm #(
  parameter int PERIOD = `OEMC_PWM_PERIOD,
  parameter int SS_PERIODS = `OEMC_SS_PERIODS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [15:0] duty_i,
  output logic hs_o,
  output logic ls_o
);

  oemc_pkg::oemc_pwm_t s_q; // Registered state
  oemc_pkg::oemc_pwm_t s_d; // Next state
  logic [15:0] off_len; // Low-side share of the period
  logic [23:0] ls_prod; // Off share times soft-start progress
  logic [15:0] ls_len; // Low-side on-time allowed now
  logic [15:0] duty; // Duty limited to the period

  // Next-state logic
  always_comb begin
    s_d = s_q;
    duty = (duty_i > 16'(PERIOD)) ? 16'(PERIOD) : duty_i;
    off_len = 16'(PERIOD) - duty;
    ls_prod = 24'(off_len) * 24'(s_q.ss);
    // RQ4 low-side ramp scaled by progress
    if (s_q.ss >= 8'(SS_PERIODS)) begin
      ls_len = off_len;
    end else begin
      ls_len = 16'(ls_prod / 24'(SS_PERIODS));
    end
    if (!run_i) begin
      // Idle: both gates low, soft-start rearmed
      s_d = '0;
    end else begin
      // RQ3 free-running fixed period
      if (s_q.cnt == 16'(PERIOD - 1)) begin
        s_d.cnt = 16'h0000;
        if (s_q.ss < 8'(SS_PERIODS)) begin
          s_d.ss = s_q.ss + 8'h01;
        end
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
      s_d.hs = s_d.cnt < duty;
      // RQ4 complementary once ramp is done
      s_d.ls = (s_d.cnt >= duty) && ((s_d.cnt - duty) < ls_len);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign hs_o = s_q.hs;
  assign ls_o = s_q.ls;

endmodule : oemc_pwm

// ===== tb/oemc_ctrl_properties.sv
// Port-level assertions for the output enable and margin control block
`timescale 1ns/1ps
module oemc_ctrl_properties #(
  parameter int TURN_UP_RAMP_TIME_CYC = 20
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic [7:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_WDATA_I,
  input wire logic [7:0] CMD_RDATA_O,
  input wire logic CMD_ACK_O,
  input wire logic CMD_NACK_O,
  input wire logic LOOP_SLAVE_I,
  input wire logic [7:0] ALERT_MASK_I,
  input wire logic VIN_OK_I,
  input wire logic OV_WARN_I,
  input wire logic HS_GATE_O,
  input wire logic LS_GATE_O,
  input wire logic POWER_GOOD_OUTPUT_O,
  input wire logic ALERT_O,
  input wire logic [7:0] STATUS_O,
  input wire logic RAMP_UP_O,
  input wire logic RAMP_DOWN_O
);
  logic [31:0] ramp_n_q; // Cycles spent in the start ramp
  wire acc_w = CE_I && (CMD_WR_I || CMD_RD_I); // Any access taken
  wire wr_w = CE_I && CMD_WR_I && CMD_ADDR_I == 8'h01 && !LOOP_SLAVE_I;
  // Counts ramp cycles to bound the ramp length
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ramp_n_q <= 32'h0;
    end else begin
      ramp_n_q <= RAMP_UP_O ? ramp_n_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  chk_slave_nack: assert property (
    acc_w && LOOP_SLAVE_I |=> CMD_NACK_O && !CMD_ACK_O)
    else $error("Loop slave access not refused");
  chk_slave_flag: assert property (
    acc_w && LOOP_SLAVE_I |=> STATUS_O[7])
    else $error("Loop slave access not flagged");
  chk_write_ack: assert property (
    wr_w |=> CMD_ACK_O && !CMD_NACK_O)
    else $error("Command write not acknowledged");
  chk_invalid_flags: assert property (
    wr_w && CMD_WDATA_I[7:6] == 2'h3 |=> STATUS_O[6] && STATUS_O[5])
    else $error("Both enable bits not flagged");
  chk_rdata_low: assert property (
    CMD_ACK_O && $past(CMD_RD_I) |-> CMD_RDATA_O[1:0] == 2'h0)
    else $error("Read-only bits not zero");
  chk_warn_power_good_output: assert property (
    OV_WARN_I ##1 OV_WARN_I |-> !POWER_GOOD_OUTPUT_O)
    else $error("Power good high during warning");
  chk_warn_status: assert property (
    OV_WARN_I |=> STATUS_O[0])
    else $error("Overvoltage warning not recorded");
  chk_alert_mask: assert property (
    $stable(ALERT_MASK_I) |-> ALERT_O == |(STATUS_O & ~ALERT_MASK_I))
    else $error("Alert does not follow unmasked status");
  chk_vin_stop: assert property (
    !VIN_OK_I [*3] |-> !HS_GATE_O && !LS_GATE_O)
    else $error("Gates driven below input lockout");
  chk_ramp_len: assert property (
    ramp_n_q <= TURN_UP_RAMP_TIME_CYC)
    else $error("Start ramp too long");
  cover property ($rose(RAMP_UP_O));
  cover property ($rose(RAMP_DOWN_O));
  cover property (CMD_NACK_O);
endmodule : oemc_ctrl_properties

bind oemc_ctrl oemc_ctrl_properties #(.TURN_UP_RAMP_TIME_CYC(TURN_UP_RAMP_TIME_CYC)) chk_i (
  .REF_CLK_I, .RESET_N_I, .CE_I, .CMD_WR_I, .CMD_RD_I, .CMD_ADDR_I,
  .CMD_WDATA_I, .CMD_RDATA_O, .CMD_ACK_O, .CMD_NACK_O, .LOOP_SLAVE_I,
  .ALERT_MASK_I, .VIN_OK_I, .OV_WARN_I, .HS_GATE_O, .LS_GATE_O,
  .POWER_GOOD_OUTPUT_O, .ALERT_O, .STATUS_O, .RAMP_UP_O, .RAMP_DOWN_O);

// ===== tb/oemc_ctrl_tb_top.sv
// Self-checking bench for the output enable and margin control block
`timescale 1ns/1ps
module oemc_ctrl_tb_top;
  localparam int TON = 20; // Shortened start ramp
  localparam int TOFF_D = 5; // Shortened turnoff wait
  localparam int TOFF_F = 10; // Shortened turnoff ramp
  localparam int PER = 20; // Shortened switching period
  localparam int SSP = 4; // Shortened soft-start length
  logic clk, rst_n, slave, clr, pin, vin, ovw, uvw, undervoltage_fault, ok; // Inputs
  logic [4:0] cfg; // On/off configuration
  logic [1:0] uvr; // Undervoltage response
  logic [7:0] mask, e, addr, wdata, rdata, status; // Port values
  logic [15:0] sp, trim, lo, hi, duty, nh, nb, target; // Wide values
  logic [3:0] sh; // Feedback scale shift
  logic wr, rd, hs, ls, pg, alert, rup, rdn, ack, nack; // Port nets
  int mismatches, n_checks; // Tallies
  oemc_host host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata), .ack_i(ack), .nack_i(nack));
  oemc_ctrl #(.TURN_UP_RAMP_TIME_CYC(TON), .TURNOFF_WAIT_TIME_CYC(TOFF_D),
    .TURNOFF_RAMP_TIME_CYC(TOFF_F), .PWM_PERIOD(PER), .SS_PERIODS(SSP)) uut (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'h1), .CMD_WR_I(wr),
    .CMD_RD_I(rd), .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata),
    .CMD_RDATA_O(rdata), .CMD_ACK_O(ack), .CMD_NACK_O(nack),
    .ON_OFF_CFG_I(cfg), .LOOP_SLAVE_I(slave), .UV_RESP_I(uvr),
    .OV_RESP_I(2'h0), .TON_RESP_I(2'h0), .ALERT_MASK_I(mask),
    .CLEAR_FAULTS_I(clr), .ENABLE_CONTROL_PIN_I(pin), .VIN_OK_I(vin),
    .OV_WARN_I(ovw), .UV_WARN_I(uvw), .OV_FAULT_I(1'h0), .UV_FAULT_I(undervoltage_fault),
    .TON_MAX_FAULT_I(1'h0), .NOMINAL_SETPOINT_I(sp), .REF_TRIM_I(trim),
    .MARGIN_LOW_STEP_I(lo), .MARGIN_HIGH_STEP_I(hi),
    .FEEDBACK_SCALE_SHIFT_I(sh), .DUTY_I(duty), .HS_GATE_O(hs),
    .LS_GATE_O(ls), .POWER_GOOD_OUTPUT_O(pg), .ALERT_O(alert),
    .STATUS_O(status), .TARGET_O(target), .RAMP_UP_O(rup),
    .RAMP_DOWN_O(rdn));
  // Clock of 10 ns
  always #5 clk = ~clk;
  // Compares and counts
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task clear;
    clr = 1'h1;
    cyc(1);
    clr = 1'h0;
  endtask : clear
  // One switching period: high-side count and equal-gate count
  task period;
    nh = 16'h0;
    nb = 16'h0;
    repeat (20) begin
      @(negedge clk);
      nh += {15'h0, hs === 1'h1};
      nb += {15'h0, ls === hs};
    end
  endtask : period
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Watchdog at about seventeen times the expected run
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end
  // Main sequence
  initial begin
    {clk, rst_n, slave, clr, pin, ovw, uvw, undervoltage_fault} = 8'h00;
    vin = 1'h1;
    cfg = 5'h16;
    uvr = 2'h1;
    mask = 8'h00;
    e = 8'h00;
    {sp, trim, lo, hi, duty} = {16'h1000, 16'h0040, 16'h0020, 16'h0010,
      16'h000A};
    sh = 4'h2;
    cyc(4);
    rst_n = 1'h1;
    host.xfer(1'h0, 8'h01, 8'h00);
    chk({host.ack, host.nack, host.rdata}, 10'h200);
    host.xfer(1'h1, 8'h01, 8'hC0);
    host.xfer(1'h0, 8'h01, 8'h00);
    chk({status[6:5], host.rdata}, 10'h300);
    // Every margin code, read-only bits written as ones
    for (int c = 0; c < 16; c++) begin
      clear;
      host.xfer(1'h1, 8'h01, {2'h0, c[3:0], 2'h3});
      ok = !(c inside {4, 7, 8, 11, 12, 13, 14, 15});
      if (ok) e = {2'h0, c[3:0], 2'h0};
      host.xfer(1'h0, 8'h01, 8'h00);
      chk({status[6], host.rdata}, {!ok, e});
    end
    // Pin-only start with the on bit clear
    pin = 1'h1;
    cyc(4);
    chk(rup, 1'h1);
    cyc(120);
    chk(target, 16'h1014);
    period;
    chk(nh, 16'h000A);
    chk(nb, 16'h0000);
    ovw = 1'h1;
    cyc(3);
    chk({pg, alert, status[0]}, 3'h3);
    period;
    chk(nh, 16'h000A);
    mask = 8'hFF;
    cyc(2);
    chk(alert, 1'h0);
    {ovw, mask} = 9'h000;
    clear;
    pin = 1'h0;
    cyc(8);
    chk(rdn, 1'h1);
    cyc(20);
    // Command-only control
    cfg = 5'h18;
    host.xfer(1'h1, 8'h01, 8'h80);
    cyc(4);
    chk(rup, 1'h1);
    cyc(30);
    host.xfer(1'h1, 8'h01, 8'hC0);
    period;
    chk(nh, 16'h000A);
    host.xfer(1'h1, 8'h01, 8'h00);
    cyc(3);
    period;
    chk({rdn, nh}, 17'h0);
    host.xfer(1'h1, 8'h01, 8'h80);
    cyc(30);
    host.xfer(1'h1, 8'h01, 8'h40);
    cyc(8);
    chk(rdn, 1'h1);
    cyc(20);
    host.xfer(1'h1, 8'h01, 8'h80);
    cyc(30);
    vin = 1'h0;
    cyc(3);
    period;
    chk(nh, 16'h0);
    vin = 1'h1;
    host.xfer(1'h1, 8'h01, 8'h00);
    cyc(5);
    // Combined pin and command control
    cfg = 5'h1C;
    host.xfer(1'h1, 8'h01, 8'h80);
    cyc(4);
    chk(rup, 1'h0);
    pin = 1'h1;
    cyc(4);
    chk(rup, 1'h1);
    cyc(25);
    host.xfer(1'h1, 8'h01, 8'h98);
    cyc(3);
    chk(target, 16'h1008);
    clear;
    // host leaves the undervoltage alert unmasked on purpose
    host.xfer(1'h1, 8'h01, 8'h84);
    undervoltage_fault = 1'h1;
    period;
    chk({status[3], alert, nh}, 18'h3000A);
    host.xfer(1'h1, 8'h01, 8'h80);
    cyc(3);
    period;
    chk({status[3], nh}, 17'h10000);
    undervoltage_fault = 1'h0;
    slave = 1'h1;
    host.xfer(1'h0, 8'h01, 8'h00);
    chk({host.ack, host.nack, status[7], alert}, 4'h7);
    finish_test;
  end
endmodule : oemc_ctrl_tb_top

// ===== tb/oemc_host.sv
// Host controller model driving the command access port
`timescale 1ns/1ps
module oemc_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic ack_i,
  input wire logic nack_i
);
  logic [7:0] rdata; // Data of the last answer
  logic ack; // Last access accepted
  logic nack; // Last access refused
  // Idle port at time zero
  initial begin
    wr_o = 1'h0;
    rd_o = 1'h0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One single-byte request, answer taken one cycle after it is driven
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    rdata = rdata_i;
    ack = ack_i;
    nack = nack_i;
    wr_o = 1'h0;
    rd_o = 1'h0;
    // Released lines show the inverse so stale values cannot pass
    addr_o = ~a;
    wdata_o = ~d;
  endtask : xfer
endmodule : oemc_host
